// ---- core/fsw_pkg.sv ----
// Purpose: Constants for the fail-safe window watchdog.
// Assumes: Time base clock comes from an external RC on a pin, sampled by the 100 MHz clock.
// Notes: Window edges are in time base clocks.
// Function
// - Trigger rising edge clears interval counter and clocks the up/down counter.
// - Up/down counter saturates between zero and three.
// - Good trigger adds one, bad trigger subtracts one.
// - Counter at three sets good flag and releases enable.
// - Counter decremented to zero clears good flag and asserts enable.
// - No trigger within 250 time base clocks clears the counter at once.
// - Missing trigger also clears the good flag.
// - Good flag shifts the window by one time base clock.
// - Stopped time base raises failure after timeout, clearing counter and flag.
// - Power-on or supply fault resets the watchdog to its initial state.
// - Initial state is count zero with fault status.
// - Time base runs at 100 times the trigger rate.
// - Period inside window is good, too short or too long is bad.
// - Normal supply: relay follows request, reset high, enable inactive.
// - Supply fault: relay off, reset low, enable active.
// - Bad triggering forces relay off and enable active.
// - Request high turns relay on; stuck trigger or RC pins give reset state.
// - Period under 79 to 80 clocks is too fast, 169 to 170 or more too slow.
// - Short supply faults ignored; long ones start a restartable reset delay.
package fsw_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TB_RATIO = 100;
   localparam logic [8:0] WIN_LOW = 9'h04F;
   localparam logic [8:0] WIN_HIGH = 9'h0A9;
   localparam logic [8:0] WIN_MISS = 9'h0FA;
   localparam logic [1:0] CNT_MIN = 2'h0;
   localparam logic [1:0] CNT_MAX = 2'h3;
   localparam int unsigned OSC_TIMEOUT_US = 1000;
   localparam int unsigned OSC_TIMEOUT_CYC = OSC_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DEBOUNCE_NS = 10_000;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_NS / 10;
   localparam int unsigned RST_DELAY_US = 1000;
   localparam int unsigned RST_DELAY_CYC = RST_DELAY_US * (CLK_HZ / 1_000_000);
endpackage

// ---- core/fsw_supply_monitor.sv ----
// Purpose: Debounces the supply fault level and stretches it into a reset delay.
// Assumes: i_fault is already synchronised.
// Notes: A fault that outlasts the debounce time during the delay restarts the delay.
`timescale 1ns/1ps
module fsw_supply_monitor #(
   parameter int unsigned DEB_CYC = 1000,
   parameter int unsigned DLY_CYC = 100000
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Fault in, hold out
   input wire logic i_fault,
   output logic o_hold
);
   initial begin
      if (DEB_CYC < 1 || DLY_CYC < 1) $error("bad supply monitor counts");
   end
   logic [31:0] deb_r;
   logic [31:0] dly_r;
   logic hold_r;
   assign o_hold = hold_r;
   ////////////////////////////////////////////////////////////////////////////
   // Pulses shorter than the debounce time never reach the delay.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         deb_r <= 32'h0;
      end else if (!i_fault) begin
         deb_r <= 32'h0;
      end else if (deb_r < DEB_CYC) begin
         deb_r <= deb_r + 32'h1;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dly_r <= 32'h0;
         hold_r <= 1'b1;
      end else if (deb_r >= DEB_CYC) begin
         dly_r <= 32'h0;
         hold_r <= 1'b1;
      end else if (hold_r) begin
         if (dly_r >= DLY_CYC - 1) begin
            hold_r <= 1'b0;
         end else begin
            dly_r <= dly_r + 32'h1;
         end
      end
   end
   a_hold_on_fault: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (deb_r >= DEB_CYC) |=> hold_r) else $error("hold not raised");
endmodule

// ---- core/failsafe_window_watchdog.sv ----
// Purpose: Window watchdog with relay gate, enable and reset outputs.
// Assumes: Pin inputs are asynchronous to i_ref_clk and are synchronised here.
// Notes: Enable and relay outputs are open drain, modelled as data plus enable.
`timescale 1ns/1ps
module failsafe_window_watchdog
   import fsw_pkg::*;
#(
   parameter int unsigned OSC_TO_CYC = fsw_pkg::OSC_TIMEOUT_CYC,
   parameter int unsigned DEB_CYC = fsw_pkg::DEBOUNCE_CYC,
   parameter int unsigned DLY_CYC = fsw_pkg::RST_DELAY_CYC
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Pins from the microcontroller and the RC
   input wire logic i_trigger_in,
   input wire logic i_relay_request_in,
   input wire logic i_rc_timebase_pin,
   // Supply fault from the analog comparators
   input wire logic i_supply_fault,
   // Outputs
   output logic o_reset_n,
   output logic o_enable_n,
   output logic o_enable_oe_n,
   output logic o_relay_on,
   output logic o_relay_oe_n,
   output logic o_watchdog_good_flag,
   output logic [1:0] o_updown_count
);
   import fsw_pkg::*;
   initial begin
      if (OSC_TO_CYC < 2 || DEB_CYC < 1 || DLY_CYC < 1) $error("bad watchdog parameters");
      if (WIN_LOW >= WIN_HIGH || WIN_HIGH >= WIN_MISS) begin
         $error("bad window edges");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for every pin input.
   localparam int unsigned N_PINS = 4;
   logic [N_PINS-1:0] pin_in;
   wire logic [N_PINS-1:0] sync2_r;
   assign pin_in = {i_supply_fault, i_rc_timebase_pin, i_relay_request_in, i_trigger_in};
   for (genvar g = 0; g < N_PINS; g++) begin : g_sync
      logic s1_r;
      logic s2_r;
      always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
         end else begin
            s1_r <= pin_in[g];
            s2_r <= s1_r;
         end
      end
      assign sync2_r[g] = s2_r;
   end
   logic trig_s;
   logic req_s;
   logic tb_s;
   logic fault_s;
   assign trig_s = sync2_r[0];
   assign req_s = sync2_r[1];
   assign tb_s = sync2_r[2];
   assign fault_s = sync2_r[3];
   logic trig_d_r;
   logic tb_d_r;
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         trig_d_r <= 1'b0;
         tb_d_r <= 1'b0;
      end else begin
         trig_d_r <= trig_s;
         tb_d_r <= tb_s;
      end
   end
   logic trig_edge;
   logic tb_tick;
   assign trig_edge = trig_s & ~trig_d_r;
   assign tb_tick = tb_s & ~tb_d_r;
   ////////////////////////////////////////////////////////////////////////////
   // Supply monitor holds the watchdog in its initial state.
   logic supply_hold;
   fsw_supply_monitor #(
      .DEB_CYC(DEB_CYC),
      .DLY_CYC(DLY_CYC)
   ) u_supply (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_fault(fault_s),
      .o_hold(supply_hold)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Time base failure detection on the system clock, so a dead RC is still seen.
   logic [31:0] osc_to_r;
   logic timebase_fail_input;
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         osc_to_r <= 32'h0;
      end else if (tb_tick) begin
         osc_to_r <= 32'h0;
      end else if (osc_to_r < OSC_TO_CYC) begin
         osc_to_r <= osc_to_r + 32'h1;
      end
   end
   assign timebase_fail_input = (osc_to_r >= OSC_TO_CYC);
   ////////////////////////////////////////////////////////////////////////////
   // Trigger interval counter in time base clocks, saturating at the miss point.
   logic [8:0] interval_r;
   logic miss;
   assign miss = (interval_r >= WIN_MISS);
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         interval_r <= 9'h000;
      end else if (supply_hold || trig_edge) begin
         interval_r <= 9'h000;
      end else if (tb_tick && !miss) begin
         interval_r <= interval_r + 9'h001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Window judgement; the good flag pushes both edges one clock later.
   logic good_r;
   logic [8:0] lo_edge;
   logic [8:0] hi_edge;
   logic in_window;
   assign lo_edge = good_r ? WIN_LOW + 9'h001 : WIN_LOW;
   assign hi_edge = good_r ? WIN_HIGH + 9'h001 : WIN_HIGH;
   assign in_window = (interval_r >= lo_edge) && (interval_r < hi_edge);
   ////////////////////////////////////////////////////////////////////////////
   // Saturating up/down counter.
   logic [1:0] count_r;
   logic clear_all;
   assign clear_all = supply_hold || timebase_fail_input || miss;
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_r <= CNT_MIN;
      end else if (clear_all) begin
         count_r <= CNT_MIN;
      end else if (trig_edge) begin
         if (in_window) begin
            if (count_r != CNT_MAX) begin
               count_r <= count_r + 2'h1;
            end
         end else if (count_r != CNT_MIN) begin
            count_r <= count_r - 2'h1;
         end
      end
   end
   // Set/reset flag: set at three, cleared at zero or on any fault.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         good_r <= 1'b0;
      end else if (clear_all) begin
         good_r <= 1'b0;
      end else if (count_r == CNT_MAX) begin
         good_r <= 1'b1;
      end else if (count_r == CNT_MIN) begin
         good_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Output stage registered; relay only follows request while all is well.
   logic reset_out_r;
   logic enable_r;
   logic relay_r;
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         reset_out_r <= 1'b0;
         enable_r <= 1'b0;
         relay_r <= 1'b0;
      end else begin
         reset_out_r <= ~supply_hold;
         enable_r <= good_r & ~supply_hold;
         relay_r <= req_s & good_r & ~supply_hold;
      end
   end
   assign o_reset_n = reset_out_r;
   assign o_enable_n = enable_r;
   assign o_enable_oe_n = enable_r;
   assign o_relay_on = relay_r;
   assign o_relay_oe_n = ~relay_r;
   assign o_watchdog_good_flag = good_r;
   assign o_updown_count = count_r;
   ////////////////////////////////////////////////////////////////////////////
   // Saturation is checked on real trigger edges, since a two-bit range check proves nothing.
   a_sat_high: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && in_window && !clear_all && count_r == CNT_MAX)
      |=> count_r == CNT_MAX)
      else $error("counter wrapped above three");

   a_sat_low: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && !in_window && count_r == CNT_MIN)
      |=> count_r == CNT_MIN)
      else $error("counter wrapped below zero");

   a_edge_clears: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      trig_edge
      |=> interval_r == 9'h000)
      else $error("interval not cleared");

   a_tick_counts: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (tb_tick && !trig_edge && !supply_hold && !miss)
      |=> interval_r == $past(interval_r) + 9'h001)
      else $error("interval did not count");

   a_miss_clears: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      miss
      |=> (count_r == CNT_MIN) && !good_r)
      else $error("miss not handled");

   a_good_at_max: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (count_r == CNT_MAX && !clear_all)
      |=> good_r)
      else $error("flag not set");

   a_good_holds: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (good_r && count_r != CNT_MIN && !clear_all)
      |=> good_r)
      else $error("flag dropped early");

   a_good_cleared: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (count_r == CNT_MIN)
      |=> !good_r)
      else $error("flag not cleared");

   a_osc_fail: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      timebase_fail_input
      |=> count_r == CNT_MIN)
      else $error("osc fail ignored");

   a_fail_flag: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      timebase_fail_input
      |=> !good_r)
      else $error("osc fail kept flag");

   a_osc_timeout: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (!tb_tick && osc_to_r == 32'(OSC_TO_CYC - 1))
      |=> timebase_fail_input)
      else $error("osc timeout missed");

   a_up_step: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && in_window && !clear_all && count_r != CNT_MAX)
      |=> count_r == $past(count_r) + 2'h1)
      else $error("no increment");

   a_down_step: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && !in_window && !clear_all && count_r != CNT_MIN)
      |=> count_r == $past(count_r) - 2'h1)
      else $error("no decrement");

   a_good_mid: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && !clear_all && interval_r > WIN_LOW && interval_r < WIN_HIGH
      && count_r != CNT_MAX)
      |=> count_r == $past(count_r) + 2'h1)
      else $error("good period not counted");

   a_fast_bad: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && !clear_all && interval_r < WIN_LOW && count_r != CNT_MIN)
      |=> count_r == $past(count_r) - 2'h1)
      else $error("fast trigger not bad");

   a_slow_bad: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (trig_edge && !clear_all && interval_r > WIN_HIGH && count_r != CNT_MIN)
      |=> count_r == $past(count_r) - 2'h1)
      else $error("slow trigger not bad");

   a_hold_clears: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      supply_hold
      |=> count_r == CNT_MIN && !good_r && interval_r == 9'h000)
      else $error("supply hold kept state");

   a_relay_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (supply_hold || !good_r)
      |=> !relay_r)
      else $error("relay not forced off");

   a_relay_follow: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (req_s && good_r && !supply_hold)
      |=> relay_r)
      else $error("relay did not follow");

   a_relay_req_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !req_s
      |=> !relay_r)
      else $error("relay on without request");

   a_enable_follow: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (good_r && !supply_hold)
      |=> enable_r)
      else $error("enable not released");

   a_enable_drop: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !good_r
      |=> !enable_r)
      else $error("enable not active");

   a_reset_high: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !supply_hold
      |=> reset_out_r)
      else $error("reset out stuck low");

   a_supply_out: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      supply_hold
      |=> !reset_out_r && !enable_r)
      else $error("supply outputs wrong");

   a_hyst_edge: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      good_r
      |-> lo_edge == WIN_LOW + 9'h001 && hi_edge == WIN_HIGH + 9'h001)
      else $error("window not shifted");

   a_hyst_free: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !good_r
      |-> lo_edge == WIN_LOW && hi_edge == WIN_HIGH)
      else $error("window shifted while bad");

endmodule

// ---- tb/mcu_model.sv ----
// Purpose: Microcontroller model that drives the trigger and relay request pins.
// Assumes: Trigger period is counted in rising edges of the RC time base pin.
// Notes: The trigger pin just stays where it is while the time base stands still.
`timescale 1ns/1ps
module mcu_model (
   // Clock and time base
   input wire logic i_ref_clk,
   input wire logic i_rc_pin,
   // Commands from the bench
   input wire logic i_req,
   input wire logic [9:0] i_period,
   // Pins and trigger tally
   output logic o_trigger_in,
   output logic o_relay_request_in,
   output logic [15:0] o_trig_cnt
);
   logic rc_d;
   logic [9:0] ticks;
   initial begin
      rc_d = 1'b0;
      ticks = 10'h000;
      o_trigger_in = 1'b0;
      o_trig_cnt = 16'h0000;
   end
   assign o_relay_request_in = i_req;
   ////////////////////////////////////////////////////////////////////////////
   // A constant period keeps the watchdog satisfied, so only the bench may vary it.
   always @(negedge i_ref_clk) begin
      rc_d <= i_rc_pin;
      if (i_rc_pin && !rc_d) begin
         if (ticks + 10'h001 >= i_period) begin
            ticks <= 10'h000;
            o_trigger_in <= 1'b1;
            o_trig_cnt <= o_trig_cnt + 16'h0001;
         end else begin
            ticks <= ticks + 10'h001;
            if (ticks == 10'h00A) begin
               o_trigger_in <= 1'b0;
            end
         end
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the fail-safe window watchdog.
// Assumes: Time base pin toggles every 2 clocks, so one tick is 4 clocks.
// Notes: Short parameters keep the time base timeout and supply delays brief.
`timescale 1ns/1ps
module tb_top;
   import fsw_pkg::*;
   typedef struct {int per; int n; logic req; logic [1:0] c; logic f; logic r;} row_t;
   logic clk = 1'b0, rst_n = 1'b0, rc_pin = 1'b0, fault = 1'b0, req = 1'b0, rc_run = 1'b1;
   logic trig, rreq, o_rst_n, en_n, en_oe_n, rly, rly_oe_n, flag;
   logic [1:0] cnt;
   logic [1:0] rc_div = 2'h0;
   logic [9:0] per = 10'h064;
   logic [15:0] tcnt;
   int n_errors = 0, cmp_count = 0, tn = 0;
   row_t rows[7] = '{
      '{100, 5, 1'b1, 2'h3, 1'b1, 1'b1},
      '{100, 1, 1'b0, 2'h3, 1'b1, 1'b0},
      '{40, 3, 1'b1, 2'h0, 1'b0, 1'b0},
      '{40, 2, 1'b1, 2'h0, 1'b0, 1'b0},
      '{100, 5, 1'b1, 2'h3, 1'b1, 1'b1},
      '{200, 1, 1'b1, 2'h2, 1'b1, 1'b1},
      '{300, 1, 1'b1, 2'h0, 1'b0, 1'b0}
   };
   always #5 clk = ~clk;
   always @(negedge clk) begin
      rc_div <= rc_div + 2'h1;
      rc_pin <= rc_run & rc_div[1];
   end
   failsafe_window_watchdog #(.OSC_TO_CYC(50), .DEB_CYC(4), .DLY_CYC(20)) dut_u (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_trigger_in(trig), .i_relay_request_in(rreq),
      .i_rc_timebase_pin(rc_pin), .i_supply_fault(fault), .o_reset_n(o_rst_n),
      .o_enable_n(en_n), .o_enable_oe_n(en_oe_n), .o_relay_on(rly),
      .o_relay_oe_n(rly_oe_n), .o_watchdog_good_flag(flag), .o_updown_count(cnt));
   mcu_model mcu_u (.i_ref_clk(clk), .i_rc_pin(rc_pin), .i_req(req), .i_period(per),
      .o_trigger_in(trig), .o_relay_request_in(rreq), .o_trig_cnt(tcnt));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic cmp_cnt(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t count got %h exp %h", $time, got, exp);
      end
   endtask
   // Enable pin and its drive follow the good flag while supply is normal.
   task automatic check_out(input logic [1:0] c, input logic f, r, e, s);
      cmp_cnt(cnt, c);
      cmp_bit(flag, f, "flag");
      cmp_bit(rly, r, "relay");
      cmp_bit(rly_oe_n, ~r, "relay drive");
      cmp_bit(en_n, e, "enable");
      cmp_bit(en_oe_n, e, "enable drive");
      cmp_bit(o_rst_n, s, "reset");
   endtask
   task automatic wait_trig(input int n);
      int k;
      logic [15:0] goal;
      goal = tcnt + 16'(n);
      for (k = 0; k < 20000 && tcnt != goal; k++) @(negedge clk);
      if (tcnt != goal) begin
         n_errors++;
         $display("MISMATCH t=%0t trigger wait ran out", $time);
      end
      repeat (12) @(negedge clk);
   endtask
   task automatic run_row(input row_t w);
      per = 10'(w.per);
      req = w.req;
      wait_trig(w.n);
      check_out(w.c, w.f, w.r, w.f, 1'b1);
      $display("test %0d done", tn++);
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #400_000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(negedge clk);
      check_out(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      rst_n = 1'b1;
      @(negedge clk);
      check_out(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test %0d done", tn++);
      foreach (rows[i]) run_row(rows[i]);
      run_row(rows[0]);
      rc_run = 1'b0;
      repeat (80) @(negedge clk);
      check_out(2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      $display("test %0d done", tn++);
      rc_run = 1'b1;
      run_row(rows[0]);
      fault = 1'b1;
      repeat (2) @(negedge clk);
      fault = 1'b0;
      repeat (10) @(negedge clk);
      check_out(2'h3, 1'b1, 1'b1, 1'b1, 1'b1);
      $display("test %0d done", tn++);
      fault = 1'b1;
      repeat (12) @(negedge clk);
      check_out(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      fault = 1'b0;
      repeat (10) @(negedge clk);
      cmp_bit(o_rst_n, 1'b0, "reset delay");
      repeat (40) @(negedge clk);
      cmp_bit(o_rst_n, 1'b1, "reset end");
      $display("test %0d done", tn++);
      report_and_stop;
   end
endmodule
